// ===== rtl/segment_lcd_setup_regs.v
// Summary of operation
// - Segment-enable bits pick which pins drive LCD segments.
// - Control holds multiplex in 1:0, timing source 3:2, sleep flag bit 6.
// - For ladder modes 2/3 regulator clock select 1:0 is written 00.
// - Regulator off: charge-pump bit 6 selects bias mode 2 or 3.
// - For modes 0/1 bias voltage level sits in regulator bits 5:3.
// - In modes 0/1 charge-pump bit turns the charge pump on or off.
// - Regulator bit 2 selects regulator bias mode for modes 0/1.
// - For modes 0/1 a nonzero regulator clock code turns regulator on.
// - Control bit 7 starts LCD operation, written as the last step.
// - Unimplemented bits read zero and do not affect operation.
// - Small package drops upper segment bits and registers holding only them.
// - Pixel write while writes disallowed sets control bit 5 error flag.
// - No frame interrupt for Type-A, nor Type-B with static drive.
`include "lcd_setup_defines.vh"

module segment_lcd_setup_regs #(
  parameter SEG_COUNT       = 48,
  parameter TICKS_PER_PHASE = `TICKS_PER_PHASE
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // Avalon-MM slave, word addressed
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Timing source ticks, one-cycle pulses
  input  wire        tick_sysclk,
  input  wire        tick_t1osc,
  input  wire        tick_intrc,
  // Power management
  input  wire        sleep_req,
  // Glass drive
  output reg  [47:0] seg_pin_select_r,
  output reg  [47:0] seg_level_r,
  output reg  [3:0]  com_level_r,
  output reg         drive_polarity_r,
  // Bias generation
  output reg  [1:0]  regulator_clk_sel_r,
  output reg  [2:0]  bias_voltage_r,
  output reg         regulator_bias_mode_r,
  output reg         charge_pump_on_r,
  output reg         ladder_mode2_r,
  output reg         ladder_mode3_r,
  // Frame event request
  output reg         frame_irq_r
);

  localparam NUM_PIX   = 24;
  localparam NUM_SEGEN = 6;
  localparam GROUPS    = 6;

  // Register storage
  reg  [7:0]  pix_r [0:NUM_PIX-1];
  reg  [7:0]  segen_r [0:NUM_SEGEN-1];
  reg  [7:0]  control_r;
  reg  [7:0]  prescale_r;
  reg  [7:0]  regulator_r;
  reg         frame_flag_r;
  reg         frame_inten_r;
  reg         window_r;

  wire [191:0] pix_flat;
  wire [191:0] pix_mask;
  wire [47:0]  segen_flat;
  wire [47:0]  seg_mask;
  wire [47:0]  seg_level_nxt;
  wire [1:0]   com_idx;
  wire         phase_step;
  wire         frame_event;
  wire         frame_start;

  // Fields
  wire [1:0] multiplex_select     = control_r[`CTL_MUX_LO +: 2];
  wire [1:0] timing_source_select = control_r[`CTL_CS_LO +: 2];
  wire       stop_in_sleep_flag   = control_r[`CTL_SLEEP];
  wire       module_enable_bit    = control_r[`CTL_EN];
  wire       pixel_write_error_flag = control_r[`CTL_PIXEL_WRITE_ERROR_FLAG];
  wire [3:0] frame_prescale_value = prescale_r[`PS_LP_LO +: 4];
  wire       waveform_type_select = prescale_r[`PS_WFT];
  wire [1:0] regulator_clock_select = regulator_r[`REG_CKSEL_LO +: 2];
  wire       charge_pump_enable   = regulator_r[`REG_CHARGE_PUMP_ENABLE];

  // Bus handshake
  wire       req       = avs_read | avs_write;
  wire       commit    = req & ~avs_waitrequest;
  wire       wr_commit = commit & avs_write & avs_byteenable[0];
  wire [7:0] wbyte     = avs_writedata[7:0];

  // Per-bit implementation masks and flattened views
  genvar gi;
  generate
    for (gi = 0; gi < 48; gi = gi + 1) begin : g_seg
      assign seg_mask[gi] = (gi < SEG_COUNT);
      assign segen_flat[gi] = segen_r[gi / 8][gi % 8] & seg_mask[gi];
      // Bit k of group i in common c is segment 8*i+k
      assign pix_mask[gi]       = seg_mask[gi];
      assign pix_mask[48 + gi]  = seg_mask[gi];
      assign pix_mask[96 + gi]  = seg_mask[gi];
      assign pix_mask[144 + gi] = seg_mask[gi];
      assign seg_level_nxt[gi] = segen_flat[gi] &
                                 pix_flat[gen_com_base(com_idx) + gi];
    end
    for (gi = 0; gi < NUM_PIX; gi = gi + 1) begin : g_pix
      assign pix_flat[gi*8 +: 8] = pix_r[gi];
    end
  endgenerate

  function [7:0] gen_com_base;
    input [1:0] c;
    begin
      gen_com_base = {c, 6'h00} - {2'h0, c, 4'h0};
    end
  endfunction

  // Timing source and run control
  reg tick_sel;
  always @* begin
    case (timing_source_select)
      2'h0:    tick_sel = tick_sysclk;
      2'h1:    tick_sel = tick_t1osc;
      default: tick_sel = tick_intrc;
    endcase
  end

  // System clock source cannot run through sleep whatever the sleep flag says
  wire sleep_halt = sleep_req & (stop_in_sleep_flag | (timing_source_select == 2'h0));
  wire run        = module_enable_bit & ~sleep_halt;

  frame_event_gen #(
    .TICKS_PER_PHASE (TICKS_PER_PHASE)
  ) u_frame (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .run           (run),
    .tick          (tick_sel),
    .prescale      (frame_prescale_value),
    .last_com      (multiplex_select),
    .com_idx_r     (com_idx),
    .phase_step_r  (phase_step),
    .frame_event_r (frame_event),
    .frame_start_r (frame_start)
  );

  // Type-B multiplexed drive needs frame-synchronous pixel updates
  wire typeb_mux     = waveform_type_select & (multiplex_select != 2'h0);
  wire frame_irq_set = run & typeb_mux & frame_event;
  wire write_allowed_status = ~module_enable_bit | ~typeb_mux | window_r;
  wire driver_active_status = run;

  // Address decode
  wire sel_pix   = (avs_address <= `OFS_PIXEL_LAST);
  wire sel_segen = (avs_address >= `OFS_SEGEN_BASE) && (avs_address <= `OFS_SEGEN_LAST);
  wire [4:0] pix_idx   = avs_address[4:0];
  wire [5:0] seg_diff  = avs_address - `OFS_SEGEN_BASE;
  wire [2:0] seg_off   = seg_diff[2:0];
  wire [7:0] pix_wmask = pix_mask[{3'h0, pix_idx} * 8 +: 8];
  wire [7:0] seg_wmask = seg_mask[{3'h0, seg_off[2:0]} * 8 +: 8];
  wire       pix_present = sel_pix & (pix_wmask != 8'h00);
  wire       seg_present = sel_segen & (seg_wmask != 8'h00);
  wire       pix_wr      = wr_commit & pix_present;

  // Read multiplexer; absent registers and spare bits read as zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (pix_present)
      rd_byte = pix_r[pix_idx] & pix_wmask;
    else if (seg_present)
      rd_byte = segen_r[seg_off[2:0]] & seg_wmask;
    else begin
      case (avs_address)
        `OFS_CONTROL:   rd_byte = control_r & 8'hef;
        `OFS_PRESCALE: begin
          rd_byte = prescale_r & `PS_WMASK;
          rd_byte[`PS_WA]     = write_allowed_status;
          rd_byte[`PS_ACTIVE] = driver_active_status;
        end
        `OFS_REGULATOR: rd_byte = regulator_r & `REG_WMASK;
        `OFS_FLAG:      rd_byte = {1'b0, frame_flag_r, 6'h00};
        `OFS_INTEN:     rd_byte = {1'b0, frame_inten_r, 6'h00};
        default:        rd_byte = 8'h00;
      endcase
    end
  end

  // Bus slave: one wait cycle, access commits while waitrequest is low
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      if (req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h00_0000, rd_byte};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Pixel and segment-enable storage
  integer i;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < NUM_PIX; i = i + 1)
        pix_r[i] <= `RST_BYTE;
      for (i = 0; i < NUM_SEGEN; i = i + 1)
        segen_r[i] <= `RST_BYTE;
    end else begin
      // Writes outside the window are still stored; the error flag reports them
      if (pix_wr)
        pix_r[pix_idx] <= wbyte & pix_wmask;
      if (wr_commit & seg_present)
        segen_r[seg_off[2:0]] <= wbyte & seg_wmask;
    end
  end

  // Configuration registers
  reg pixel_write_error_flag_nxt;
  always @* begin
    pixel_write_error_flag_nxt = pixel_write_error_flag;
    if (wr_commit && avs_address == `OFS_CONTROL)
      pixel_write_error_flag_nxt = pixel_write_error_flag & wbyte[`CTL_PIXEL_WRITE_ERROR_FLAG];
    // Set wins over a clear in the same cycle
    if (pix_wr && !write_allowed_status)
      pixel_write_error_flag_nxt = 1'b1;
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      control_r     <= `RST_BYTE;
      prescale_r    <= `RST_BYTE;
      regulator_r   <= `RST_BYTE;
      frame_flag_r  <= 1'b0;
      frame_inten_r <= 1'b0;
    end else begin
      control_r[`CTL_PIXEL_WRITE_ERROR_FLAG] <= pixel_write_error_flag_nxt;
      if (wr_commit) begin
        case (avs_address)
          `OFS_CONTROL: begin
            control_r[`CTL_MUX_LO +: 2] <= wbyte[`CTL_MUX_LO +: 2];
            control_r[`CTL_CS_LO +: 2]  <= wbyte[`CTL_CS_LO +: 2];
            control_r[`CTL_SLEEP]       <= wbyte[`CTL_SLEEP];
            control_r[`CTL_EN]          <= wbyte[`CTL_EN];
          end
          `OFS_PRESCALE: begin
            prescale_r[`PS_LP_LO +: 4] <= wbyte[`PS_LP_LO +: 4];
            prescale_r[`PS_BIAS_MODE_SELECT]     <= wbyte[`PS_BIAS_MODE_SELECT];
            prescale_r[`PS_WFT]        <= wbyte[`PS_WFT];
          end
          `OFS_REGULATOR: regulator_r <= wbyte & `REG_WMASK;
          `OFS_INTEN:     frame_inten_r <= wbyte[`INTEN_FRAME];
          default: ;
        endcase
      end
      if (frame_irq_set)
        frame_flag_r <= 1'b1;
      else if (wr_commit && avs_address == `OFS_FLAG)
        frame_flag_r <= frame_flag_r & wbyte[`FLAG_FRAME];
    end
  end

  // Pixel update window: opens at frame event, closes after first phase of next frame for three or four commons
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      window_r <= 1'b0;
    else if (!run)
      window_r <= 1'b0;
    else if (frame_event)
      window_r <= 1'b1;
    else if (phase_step && com_idx == 2'h1)
      window_r <= 1'b0;
  end

  // Glass and bias outputs, all registered
  wire regulator_on = (regulator_clock_select != 2'h0);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      seg_pin_select_r      <= 48'h0000_0000_0000;
      seg_level_r           <= 48'h0000_0000_0000;
      com_level_r           <= 4'h0;
      drive_polarity_r      <= 1'b0;
      regulator_clk_sel_r   <= 2'h0;
      bias_voltage_r        <= 3'h0;
      regulator_bias_mode_r <= 1'b0;
      charge_pump_on_r      <= 1'b0;
      ladder_mode2_r        <= 1'b0;
      ladder_mode3_r        <= 1'b0;
      frame_irq_r           <= 1'b0;
    end else begin
      seg_pin_select_r    <= segen_flat;
      // Minimum voltage on all lines when stopped
      seg_level_r         <= run ? (seg_level_nxt ^ {48{drive_polarity_r}}) : 48'h0000_0000_0000;
      com_level_r         <= run ? (4'h1 << com_idx) : 4'h0;
      if (!run)
        drive_polarity_r <= 1'b0;
      else if (waveform_type_select ? frame_start : phase_step)
        drive_polarity_r <= ~drive_polarity_r;
      regulator_clk_sel_r   <= regulator_clock_select;
      bias_voltage_r        <= regulator_on ? regulator_r[`REG_BIAS_LO +: 3] : 3'h0;
      regulator_bias_mode_r <= regulator_on & regulator_r[`REG_MODE];
      charge_pump_on_r      <= regulator_on & charge_pump_enable;
      ladder_mode2_r        <= ~regulator_on & charge_pump_enable;
      ladder_mode3_r        <= ~regulator_on & ~charge_pump_enable;
      frame_irq_r           <= frame_flag_r & frame_inten_r;
    end
  end

endmodule

// ===== rtl/lcd_setup_defines.vh
`ifndef LCD_SETUP_DEFINES_VH
`define LCD_SETUP_DEFINES_VH

// Word offsets on the register bus
`define OFS_PIXEL_BASE   6'h00
`define OFS_PIXEL_LAST   6'h17
`define OFS_SEGEN_BASE   6'h18
`define OFS_SEGEN_LAST   6'h1d
`define OFS_CONTROL      6'h1e
`define OFS_PRESCALE     6'h1f
`define OFS_REGULATOR    6'h20
`define OFS_FLAG         6'h21
`define OFS_INTEN        6'h22

// Display control fields
`define CTL_MUX_LO       0
`define CTL_CS_LO        2
`define CTL_PIXEL_WRITE_ERROR_FLAG         5
`define CTL_SLEEP        6
`define CTL_EN           7
`define CTL_WMASK        8'hcf

// Prescale and phase fields
`define PS_LP_LO         0
`define PS_WA            4
`define PS_ACTIVE        5
`define PS_BIAS_MODE_SELECT        6
`define PS_WFT           7
`define PS_WMASK         8'hcf

// Bias regulator fields
`define REG_CKSEL_LO     0
`define REG_MODE         2
`define REG_BIAS_LO      3
`define REG_CHARGE_PUMP_ENABLE         6
`define REG_WMASK        8'h7f

// Peripheral flag and enable bits
`define FLAG_FRAME       6
`define INTEN_FRAME      6

// Reset values
`define RST_BYTE         8'h00

// Timing: source ticks per phase before the frame prescaler
`define TICKS_PER_PHASE  4

`endif

// ===== rtl/frame_event_gen.v
`include "lcd_setup_defines.vh"

module frame_event_gen #(
  parameter TICKS_PER_PHASE = `TICKS_PER_PHASE
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // Control
  input  wire       run,
  input  wire       tick,
  input  wire [3:0] prescale,
  input  wire [1:0] last_com,
  // Timing
  output reg  [1:0] com_idx_r,
  output reg        phase_step_r,
  output reg        frame_event_r,
  output reg        frame_start_r
);

  reg  [7:0] sub_r;
  reg  [3:0] pre_r;
  wire       sub_end = (sub_r == TICKS_PER_PHASE - 1);
  wire       pre_end = (pre_r == prescale);
  wire       step    = tick & sub_end & pre_end;
  wire       wrap    = (com_idx_r == last_com);
  wire [1:0] com_nxt = wrap ? 2'h0 : com_idx_r + 2'h1;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sub_r         <= 8'h00;
      pre_r         <= 4'h0;
      com_idx_r     <= 2'h0;
      phase_step_r  <= 1'b0;
      frame_event_r <= 1'b0;
      frame_start_r <= 1'b0;
    end else if (!run) begin
      // Restart from common 0 so enabling always begins on a frame boundary
      sub_r         <= 8'h00;
      pre_r         <= 4'h0;
      com_idx_r     <= 2'h0;
      phase_step_r  <= 1'b0;
      frame_event_r <= 1'b0;
      frame_start_r <= 1'b0;
    end else begin
      phase_step_r  <= step;
      frame_start_r <= step & wrap;
      // Last common entered: all data of this frame has been fetched
      frame_event_r <= step & (com_nxt == last_com);
      if (tick) begin
        sub_r <= sub_end ? 8'h00 : sub_r + 8'h01;
        if (sub_end)
          pre_r <= pre_end ? 4'h0 : pre_r + 4'h1;
      end
      if (step)
        com_idx_r <= com_nxt;
    end
  end

endmodule

// ===== testbench/lcd_regs_sva.sv
module lcd_regs_sva #(
  parameter SEG_COUNT = 48
) (
  // Clock and reset
  input logic        mclk,
  input logic        sys_rst,
  // Register bus
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  // Glass and bias
  input logic [47:0] seg_pin_select_r,
  input logic [47:0] seg_level_r,
  input logic [3:0]  com_level_r,
  input logic [1:0]  regulator_clk_sel_r,
  input logic [2:0]  bias_voltage_r,
  input logic        charge_pump_on_r,
  input logic        ladder_mode2_r,
  input logic        ladder_mode3_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_after_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_answer_bound: assert property ($rose(avs_read || avs_write) |-> ##1 !avs_waitrequest)
    else $error("answer not after one wait state");
  a_read_high_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_pump_needs_clk: assert property (charge_pump_on_r |-> regulator_clk_sel_r != 2'b00)
    else $error("charge pump on with regulator off");
  a_ladder_reg_off: assert property ((ladder_mode2_r || ladder_mode3_r) |->
    regulator_clk_sel_r == 2'b00 && !charge_pump_on_r)
    else $error("ladder mode with regulator on");
  a_ladder_pick_one: assert property ((!$past(sys_rst) && regulator_clk_sel_r == 2'b00) |->
    (ladder_mode2_r ^ ladder_mode3_r))
    else $error("ladder mode not exactly one");
  a_bias_off_zero: assert property (regulator_clk_sel_r == 2'b00 |-> bias_voltage_r == 3'h0)
    else $error("bias voltage driven with regulator off");
  a_com_one_hot: assert property ($onehot0(com_level_r))
    else $error("more than one common active");
  a_stop_blank: assert property (com_level_r == 4'h0 |-> seg_level_r == 48'h0)
    else $error("segments driven while stopped");
  a_sel_mask: assert property ((seg_pin_select_r >> SEG_COUNT) == 48'h0)
    else $error("absent segment enabled");
endmodule

// ===== testbench/lcd_glass_model.sv
module lcd_glass_model (
  input  logic        mclk,
  input  logic [3:0]  com_level_r,
  input  logic [47:0] seg_level_r,
  input  logic        drive_polarity_r,
  output logic [47:0] image [4]
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undo the drive inversion so the image reads as stored pixel bits
  always @(posedge mclk) begin
    for (int c = 0; c < 4; c++)
      if (com_level_r == (4'h1 << c))
        image[c] <= seg_level_r ^ {48{drive_polarity_r}};
  end
endmodule

// ===== testbench/segment_lcd_setup_regs_tb_top.sv
module segment_lcd_setup_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic        tick_sysclk = 1'b0;
  logic        sleep_req = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [47:0] seg_pin_select_r;
  logic [47:0] seg_level_r;
  logic [3:0]  com_level_r;
  logic        drive_polarity_r;
  logic [1:0]  regulator_clk_sel_r;
  logic [2:0]  bias_voltage_r;
  logic        regulator_bias_mode_r;
  logic        charge_pump_on_r;
  logic        ladder_mode2_r;
  logic        ladder_mode3_r;
  logic        frame_irq_r;
  logic [47:0] image [4];
  logic [7:0]  q;
  int          failures = 0;
  int          checks_done = 0;

  segment_lcd_setup_regs #(.SEG_COUNT(48), .TICKS_PER_PHASE(1)) uut (
    .mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tick_sysclk,
    .tick_t1osc(1'b0), .tick_intrc(1'b0), .sleep_req, .seg_pin_select_r, .seg_level_r,
    .com_level_r, .drive_polarity_r, .regulator_clk_sel_r, .bias_voltage_r,
    .regulator_bias_mode_r, .charge_pump_on_r, .ladder_mode2_r, .ladder_mode3_r, .frame_irq_r);

  lcd_glass_model glass (.mclk, .com_level_r, .seg_level_r, .drive_polarity_r, .image);

  always #5 mclk = ~mclk;

  task results;
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      results();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wait_com(input logic [3:0] v);
    int n;
    n = 0;
    while (com_level_r !== v && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (n == 400) begin
      failures++;
      results();
    end
  endtask

  function logic [7:0] pat(input int i);
    return 8'(i * 37 + 5);
  endfunction

  function logic [7:0] se(input int g);
    return (g == 5) ? 8'h3c : 8'hff;
  endfunction

  task t_reset_reads;
    for (int a = 0; a < 36; a++) begin
      if (a == 31)
        continue;
      bus(0, (a == 35) ? 6'h3f : 6'(a), 8'h00);
      chk("reset_read", 48'h0, {40'h0, q});
    end
  endtask

  task t_field_masks;
    bus(1, 6'h1e, 8'h1f);
    bus(0, 6'h1e, 8'h00);
    chk("control_mask", 48'h0f, {40'h0, q});
    bus(1, 6'h20, 8'hff);
    bus(0, 6'h20, 8'h00);
    chk("regulator_mask", 48'h7f, {40'h0, q});
    bus(1, 6'h1d, 8'ha5);
    bus(0, 6'h1d, 8'h00);
    chk("segment_enable", 48'ha5, {40'h0, q});
  endtask

  task t_regulator;
    logic [7:0] v [4] = '{8'h78, 8'h00, 8'h6d, 8'h2a};
    logic [8:0] e [4] = '{9'b000000010, 9'b000000001, 9'b011011100, 9'b101010000};
    for (int i = 0; i < 4; i++) begin
      bus(1, 6'h20, v[i]);
      repeat (3) @(posedge mclk);
      chk("regulator", {39'h0, e[i]}, {39'h0, regulator_clk_sel_r, bias_voltage_r,
        regulator_bias_mode_r, charge_pump_on_r, ladder_mode2_r, ladder_mode3_r});
    end
  endtask

  // Enable is withheld from control until every other step is done
  task t_setup(input logic [7:0] ps, input logic [7:0] ctl);
    bus(1, 6'h1f, ps);
    for (int g = 0; g < 6; g++)
      bus(1, 6'(24 + g), se(g));
    bus(1, 6'h1e, ctl & 8'h7f);
    for (int i = 0; i < 24; i++)
      bus(1, 6'(i), pat(i));
    bus(1, 6'h20, 8'h6d);
    bus(1, 6'h21, 8'h00);
    bus(1, 6'h22, 8'h40);
    bus(1, 6'h1e, ctl);
  endtask

  task t_glass;
    logic [47:0] sel;
    sel = {se(5), se(4), se(3), se(2), se(1), se(0)};
    t_setup(8'h0f, 8'h83);
    repeat (160) @(posedge mclk);
    chk("segment_select", sel, seg_pin_select_r);
    for (int c = 0; c < 4; c++)
      chk("glass_image", {pat(6*c+5), pat(6*c+4), pat(6*c+3), pat(6*c+2), pat(6*c+1),
        pat(6*c)} & sel, image[c] & sel);
  endtask

  task t_frame_irq;
    t_setup(8'h8f, 8'h83);
    repeat (200) @(posedge mclk);
    chk("irq_type_b", 48'h1, {47'h0, frame_irq_r});
    wait_com(4'h2);
    bus(1, 6'h00, 8'h55);
    bus(0, 6'h1e, 8'h00);
    chk("write_error", 48'ha3, {40'h0, q});
    bus(1, 6'h1e, 8'h83);
    bus(1, 6'h1f, 8'h0f);
    bus(1, 6'h21, 8'h00);
    wait_com(4'h2);
    bus(1, 6'h00, 8'h55);
    repeat (200) @(posedge mclk);
    chk("irq_type_a", 48'h0, {47'h0, frame_irq_r});
    bus(0, 6'h1e, 8'h00);
    chk("no_error", 48'h83, {40'h0, q});
    bus(1, 6'h1f, 8'h8f);
    bus(1, 6'h1e, 8'h80);
    bus(1, 6'h21, 8'h00);
    repeat (200) @(posedge mclk);
    chk("irq_static", 48'h0, {47'h0, frame_irq_r});
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    tick_sysclk <= 1'b1;
    t_reset_reads();
    t_field_masks();
    t_regulator();
    t_glass();
    t_frame_irq();
    results();
  end
endmodule

bind segment_lcd_setup_regs lcd_regs_sva #(.SEG_COUNT(SEG_COUNT)) sva_i (
  .mclk, .sys_rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .seg_pin_select_r, .seg_level_r, .com_level_r, .regulator_clk_sel_r, .bias_voltage_r,
  .charge_pump_on_r, .ladder_mode2_r, .ladder_mode3_r);
